// file: src/frame_check_pkg.sv
// How it works
// - checksum accumulator starts every frame at all ones
// - each byte is XORed into the accumulator's low byte, bit 0 aligned
// - each step shifts right once, XORing the reflected polynomial on a one out
// - eight shift steps per byte before the next byte is folded in
// - RTU check covers station address through last data byte
// - RTU check value goes out low byte first, then high byte
// - ASCII LRC is the negated modulo-256 sum of address through data
// - LRC is sent as two hex characters, upper nibble first, before terminator
// - ASCII frames end with carriage return then line feed
// - RTU frame ends after four character times of line silence
// - read answer is address, 03, byte count, words high byte first, check
// - write single word 06 is echoed with identical address, value, check
// - ASCII carries each byte as two hex characters 0-9 and A-F
// - only station addresses 1 to 254 select this drive
package frame_check_pkg;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [7:0] CH_START = 8'h3A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hFE;
  localparam int CRC_STEPS = 8;
  localparam int GAP_CHARS = 4;
  localparam int BUF_DEPTH = 8;
  localparam logic [3:0] REQ_RTU_BYTES = 4'h8;
  localparam logic [3:0] REQ_ASCII_BYTES = 4'h7;
  localparam logic [4:0] WRITE_LEN = 5'h06;
  localparam logic [15:0] MAX_WORDS = 16'h000C;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_EVAL = 6'h02,
    S_LOAD = 6'h04,
    S_WAIT = 6'h08,
    S_FETCH = 6'h10,
    S_LATCH = 6'h20
  } state_t;

  typedef enum logic [3:0] {
    SEG_START = 4'h1,
    SEG_BODY = 4'h2,
    SEG_CHECK = 4'h4,
    SEG_TAIL = 4'h8
  } seg_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < CRC_STEPS; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? (CH_ZERO + {4'h0, n}) : (CH_A + {4'h0, n - 4'hA});
  endfunction : hex_char

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c >= CH_ZERO && c <= CH_NINE) begin
      d = c - CH_ZERO;
      return {1'b1, d[3:0]};
    end
    if (c >= CH_A && c <= CH_F) begin
      d = c - CH_A + 8'h0A;
      return {1'b1, d[3:0]};
    end
    return 5'h00;
  endfunction : hex_val
endpackage : frame_check_pkg

// file: src/serial_slave_frame_check.sv
`timescale 1ns/1ps
module serial_slave_frame_check import frame_check_pkg::*; (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // configuration
  input wire logic ascii_mode_in,
  input wire logic [7:0] station_addr_in,
  input wire logic [15:0] char_cycles_in,
  // received characters from the uart
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  // characters to the uart
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  // word access to the drive data
  output logic rd_req_out,
  output logic wr_req_out,
  output logic [15:0] addr_out,
  output logic [15:0] wr_data_out,
  input wire logic [15:0] rd_data_in,
  // frame status pulses
  output logic frame_ok_out,
  output logic frame_drop_out
);
  state_t state, next_state;
  seg_t seg, next_seg;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [7:0] next_buf [BUF_DEPTH];
  logic [3:0] cnt, next_cnt;
  logic rx_nib, next_rx_nib;
  logic [3:0] rx_hi, next_rx_hi;
  logic got_cr, next_got_cr;
  logic in_frame, next_in_frame;
  logic bad, next_bad;
  logic [7:0] sum, next_sum;
  logic [15:0] crc, next_crc, crc_d1, next_crc_d1, crc_d2, next_crc_d2;
  logic [17:0] idle, next_idle;
  logic [7:0] fn, next_fn;
  logic [4:0] nwords, next_nwords;
  logic [4:0] idx, next_idx, len, next_len;
  logic tx_nib, next_tx_nib;
  logic [7:0] tx_lrc, next_tx_lrc;
  logic [15:0] tx_crc, next_tx_crc;
  logic [15:0] word, next_word;
  logic [7:0] next_tx_byte;
  logic next_tx_valid, next_rd_req, next_wr_req, next_ok, next_drop;
  logic [15:0] next_addr, next_wr_data;
  logic [7:0] pay, lrc_val;
  logic [17:0] gap;
  logic [15:0] req_words;

  assign gap = 18'(char_cycles_in) * 18'(GAP_CHARS);
  assign req_words = {buf_mem[4], buf_mem[5]};
  assign lrc_val = 8'h00 - tx_lrc;

  // payload byte of the answer at position idx
  always_comb begin
    if (idx == 5'h00) begin
      pay = station_addr_in;
    end else if (idx == 5'h01) begin
      pay = fn;
    end else if (fn == FN_WRITE) begin
      pay = buf_mem[idx[2:0]];
    end else if (idx == 5'h02) begin
      pay = {2'b00, nwords, 1'b0};
    end else begin
      pay = idx[0] ? word[15:8] : word[7:0];
    end
  end

  always_comb begin
    logic [7:0] b;
    logic store;
    logic [4:0] hv;
    logic frame_end;
    logic [4:0] ni;
    b = rx_byte_in;
    store = 1'b0;
    hv = hex_val(rx_byte_in);
    frame_end = 1'b0;
    ni = idx + 5'h01;
    next_state = state;
    next_seg = seg;
    for (int i = 0; i < BUF_DEPTH; i++) begin
      next_buf[i] = buf_mem[i];
    end
    next_cnt = cnt;
    next_rx_nib = rx_nib;
    next_rx_hi = rx_hi;
    next_got_cr = got_cr;
    next_in_frame = in_frame;
    next_bad = bad;
    next_sum = sum;
    next_crc = crc;
    next_crc_d1 = crc_d1;
    next_crc_d2 = crc_d2;
    next_idle = (rx_valid_in || &idle) ? idle : idle + 18'h00001;
    next_fn = fn;
    next_nwords = nwords;
    next_idx = idx;
    next_len = len;
    next_tx_nib = tx_nib;
    next_tx_lrc = tx_lrc;
    next_tx_crc = tx_crc;
    next_word = word;
    next_tx_byte = tx_byte_out;
    next_tx_valid = tx_valid_out;
    next_wr_req = 1'b0;
    next_ok = 1'b0;
    next_drop = 1'b0;
    next_addr = addr_out;
    next_wr_data = wr_data_out;
    case (state)
      S_IDLE: begin
        if (rx_valid_in && ascii_mode_in) begin
          if (rx_byte_in == CH_START) begin
            next_in_frame = 1'b1;
            next_cnt = 4'h0;
            next_sum = 8'h00;
            next_bad = 1'b0;
            next_got_cr = 1'b0;
            next_rx_nib = 1'b0;
          end else if (in_frame) begin
            if (rx_byte_in == CH_CR) begin
              next_got_cr = 1'b1;
            end else if (rx_byte_in == CH_LF && got_cr) begin
              frame_end = 1'b1;
              next_bad = bad | rx_nib;
            end else if (hv[4] && !got_cr) begin
              next_rx_nib = ~rx_nib;
              next_rx_hi = hv[3:0];
              b = {rx_hi, hv[3:0]};
              store = rx_nib;
            end else begin
              next_bad = 1'b1;
            end
          end
        end else if (rx_valid_in) begin
          next_idle = 18'h00000;
          store = 1'b1;
          next_in_frame = 1'b1;
          if (!in_frame) begin
            next_cnt = 4'h0;
            next_crc = CRC_PRESET;
          end
        end else if (in_frame && !ascii_mode_in && idle >= gap) begin
          frame_end = 1'b1;
        end
        if (store) begin
          if (next_cnt < 4'(BUF_DEPTH)) begin
            next_buf[next_cnt[2:0]] = b;
          end
          if (next_cnt <= 4'(BUF_DEPTH)) begin
            next_cnt = next_cnt + 4'h1;
          end
          next_sum = next_sum + b;
          next_crc_d2 = crc_d1;
          next_crc_d1 = next_crc;
          next_crc = crc_byte(next_crc, b);
        end
        if (frame_end) begin
          next_in_frame = 1'b0;
          next_state = S_EVAL;
        end
      end
      S_EVAL: begin
        next_state = S_IDLE;
        next_idx = 5'h00;
        next_tx_nib = 1'b0;
        next_tx_lrc = 8'h00;
        next_tx_crc = CRC_PRESET;
        next_seg = ascii_mode_in ? SEG_START : SEG_BODY;
        next_fn = buf_mem[1];
        next_addr = {buf_mem[2], buf_mem[3]};
        next_nwords = req_words[4:0];
        next_drop = 1'b1;
        // crc_d2 holds the crc over the six bytes before the check pair
        if ((ascii_mode_in ? (cnt == REQ_ASCII_BYTES && sum == 8'h00 && !bad)
             : (cnt == REQ_RTU_BYTES &&
                crc_d2 == {buf_mem[7], buf_mem[6]})) &&
            buf_mem[0] == station_addr_in &&
            station_addr_in >= ADDR_MIN &&
            station_addr_in <= ADDR_MAX) begin
          if (buf_mem[1] == FN_READ && req_words != 16'h0000 &&
              req_words <= MAX_WORDS) begin
            next_len = 5'h03 + {req_words[3:0], 1'b0};
            next_drop = 1'b0;
            next_ok = 1'b1;
            next_state = S_LOAD;
          end else if (buf_mem[1] == FN_WRITE) begin
            next_len = WRITE_LEN;
            next_wr_data = req_words;
            next_wr_req = 1'b1;
            next_drop = 1'b0;
            next_ok = 1'b1;
            next_state = S_LOAD;
          end
        end
      end
      S_LOAD: begin
        next_tx_valid = 1'b1;
        next_state = S_WAIT;
        case (seg)
          SEG_START: next_tx_byte = CH_START;
          SEG_BODY: begin
            next_tx_byte = !ascii_mode_in ? pay
              : hex_char(tx_nib ? pay[3:0] : pay[7:4]);
          end
          SEG_CHECK: begin
            if (ascii_mode_in) begin
              next_tx_byte = hex_char(tx_nib ? lrc_val[3:0] : lrc_val[7:4]);
            end else begin
              next_tx_byte = tx_nib ? tx_crc[15:8] : tx_crc[7:0];
            end
          end
          default: next_tx_byte = tx_nib ? CH_LF : CH_CR;
        endcase
      end
      S_WAIT: begin
        if (tx_ready_in) begin
          next_tx_valid = 1'b0;
          next_state = S_LOAD;
          next_tx_nib = ~tx_nib;
          case (seg)
            SEG_START: begin
              next_tx_nib = 1'b0;
              next_seg = SEG_BODY;
            end
            SEG_BODY: begin
              if (!ascii_mode_in || tx_nib) begin
                next_tx_nib = 1'b0;
                next_tx_lrc = tx_lrc + pay;
                next_tx_crc = crc_byte(tx_crc, pay);
                next_idx = ni;
                if (ni == len) begin
                  next_seg = SEG_CHECK;
                end else if (fn == FN_READ && ni[0] && ni >= 5'h03) begin
                  next_state = S_FETCH;
                end
              end
            end
            SEG_CHECK: begin
              if (tx_nib) begin
                next_seg = SEG_TAIL;
                if (!ascii_mode_in) begin
                  next_state = S_IDLE;
                end
              end
            end
            default: begin
              if (tx_nib) begin
                next_state = S_IDLE;
              end
            end
          endcase
        end
      end
      S_FETCH: next_state = S_LATCH;
      S_LATCH: begin
        next_word = rd_data_in;
        next_addr = addr_out + 16'h0001;
        next_state = S_LOAD;
      end
      default: next_state = S_IDLE;
    endcase
    next_rd_req = (next_state == S_FETCH);
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= S_IDLE;
      seg <= SEG_BODY;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= 8'h00;
      end
      cnt <= 4'h0;
      rx_nib <= 1'b0;
      rx_hi <= 4'h0;
      got_cr <= 1'b0;
      in_frame <= 1'b0;
      bad <= 1'b0;
      sum <= 8'h00;
      crc <= CRC_PRESET;
      crc_d1 <= CRC_PRESET;
      crc_d2 <= CRC_PRESET;
      idle <= 18'h00000;
      fn <= 8'h00;
      nwords <= 5'h00;
      idx <= 5'h00;
      len <= 5'h00;
      tx_nib <= 1'b0;
      tx_lrc <= 8'h00;
      tx_crc <= CRC_PRESET;
      word <= 16'h0000;
      tx_byte_out <= 8'h00;
      tx_valid_out <= 1'b0;
      rd_req_out <= 1'b0;
      wr_req_out <= 1'b0;
      addr_out <= 16'h0000;
      wr_data_out <= 16'h0000;
      frame_ok_out <= 1'b0;
      frame_drop_out <= 1'b0;
    end else begin
      state <= next_state;
      seg <= next_seg;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= next_buf[i];
      end
      cnt <= next_cnt;
      rx_nib <= next_rx_nib;
      rx_hi <= next_rx_hi;
      got_cr <= next_got_cr;
      in_frame <= next_in_frame;
      bad <= next_bad;
      sum <= next_sum;
      crc <= next_crc;
      crc_d1 <= next_crc_d1;
      crc_d2 <= next_crc_d2;
      idle <= next_idle;
      fn <= next_fn;
      nwords <= next_nwords;
      idx <= next_idx;
      len <= next_len;
      tx_nib <= next_tx_nib;
      tx_lrc <= next_tx_lrc;
      tx_crc <= next_tx_crc;
      word <= next_word;
      tx_byte_out <= next_tx_byte;
      tx_valid_out <= next_tx_valid;
      rd_req_out <= next_rd_req;
      wr_req_out <= next_wr_req;
      addr_out <= next_addr;
      wr_data_out <= next_wr_data;
      frame_ok_out <= next_ok;
      frame_drop_out <= next_drop;
    end
  end
endmodule : serial_slave_frame_check

// file: sim/frame_check_assertions.sv
`timescale 1ns/1ps
module frame_check_checker (
  // clock and configuration
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic ascii_mode_in,
  input wire logic [7:0] station_addr_in,
  input wire logic [15:0] char_cycles_in,
  // traffic and status
  input wire logic rx_valid_in,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic rd_req_out,
  input wire logic wr_req_out,
  input wire logic [15:0] addr_out,
  input wire logic frame_ok_out,
  input wire logic frame_drop_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [17:0] idle;
  logic [17:0] next_idle;
  logic [17:0] gap;
  assign gap = {char_cycles_in, 2'b00};
  // saturates so a long quiet line cannot wrap
  always_comb begin
    next_idle = idle;
    if (rx_valid_in) next_idle = '0;
    else if (idle != 18'h3FFFF) next_idle = idle + 18'h00001;
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) idle <= '0;
    else idle <= next_idle;
  end
  chk_gap_end: assert property (
    (frame_ok_out || frame_drop_out) && !ascii_mode_in
    |-> idle >= gap && idle <= gap + 18'h00004)
    else $error("rtu frame ended off the silent gap");
  chk_drop_silent: assert property (
    frame_drop_out |=> (!tx_valid_out) [*8])
    else $error("dropped frame was answered");
  chk_ok_excl: assert property (
    !(frame_ok_out && frame_drop_out))
    else $error("frame both accepted and dropped");
  chk_echo_addr: assert property (
    frame_ok_out && !ascii_mode_in
    |=> tx_valid_out && tx_byte_out == station_addr_in)
    else $error("answer does not open with station address");
  chk_ascii_open: assert property (
    frame_ok_out && ascii_mode_in
    |=> tx_valid_out && tx_byte_out == 8'h3A)
    else $error("ascii answer missing start marker");
  chk_ascii_chars: assert property (
    tx_valid_out && ascii_mode_in |-> tx_byte_out inside
    {8'h3A, 8'h0D, 8'h0A, [8'h30:8'h39], [8'h41:8'h46]})
    else $error("ascii answer holds a non hex character");
  chk_rd_step: assert property (
    rd_req_out |-> ##2 addr_out == $past(addr_out, 2) + 16'h0001)
    else $error("word address did not step after read");
  chk_addr_range: assert property (
    frame_ok_out |-> station_addr_in != 8'h00 && station_addr_in != 8'hFF)
    else $error("answer given at an unusable station address");
  chk_wr_at_ok: assert property (
    wr_req_out |-> frame_ok_out)
    else $error("write issued outside an accepted frame");
  chk_tx_hold: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
    else $error("answer byte changed before acceptance");
  cover property (frame_ok_out && ascii_mode_in);
  cover property (frame_ok_out && !ascii_mode_in);
  cover property (frame_drop_out);
  cover property (rd_req_out);
endmodule : frame_check_checker

bind serial_slave_frame_check frame_check_checker u_frame_check_checker (
  .sys_clk_in, .sys_rst_in, .ascii_mode_in, .station_addr_in,
  .char_cycles_in, .rx_valid_in, .tx_byte_out, .tx_valid_out,
  .tx_ready_in, .rd_req_out, .wr_req_out, .addr_out, .frame_ok_out,
  .frame_drop_out);

// file: sim/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic sys_clk_in,
  // requests towards the drive
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  // answers from the drive
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic slow_in
);
  typedef logic [7:0] bytes_t[$];
  bytes_t got;
  logic [1:0] tick = 2'h0;
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // slow mode takes one cycle in four to stretch the hold
  always @(posedge sys_clk_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out) got.push_back(tx_byte_in);
    tick = tick + 2'h1;
    #1 tx_ready_out = !slow_in || tick == 2'h0;
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return 8'h30 + {4'h0, n} + (n > 4'h9 ? 8'h07 : 8'h00);
  endfunction : hx
  function automatic bytes_t enc(input logic asc, input bytes_t b);
    bytes_t q;
    logic [15:0] c;
    logic [7:0] s;
    c = 16'hFFFF;
    s = 8'h00;
    foreach (b[i]) begin
      s = s + b[i];
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    s = -s;
    if (!asc) return {b, c[7:0], c[15:8]};
    q = {8'h3A};
    foreach (b[i]) q = {q, hx(b[i][7:4]), hx(b[i][3:0])};
    return {q, hx(s[7:4]), hx(s[3:0]), 8'h0D, 8'h0A};
  endfunction : enc
  task automatic send(input bytes_t q);
    foreach (q[i]) begin
      @(posedge sys_clk_in);
      #1 rx_byte_out = q[i];
      rx_valid_out = 1'b1;
      @(posedge sys_clk_in);
      // released line shows the inverse, not a stale byte
      #1 rx_byte_out = ~q[i];
      rx_valid_out = 1'b0;
    end
  endtask : send
endmodule : host_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef logic [7:0] bytes_t[$];
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ascii_mode = 1'b0;
  logic slow = 1'b0;
  logic [7:0] station = 8'h01;
  logic [7:0] rx_byte, tx_byte;
  logic rx_valid, tx_valid, tx_ready, rd_req, wr_req, frame_ok, frame_drop;
  logic [15:0] addr, wr_data;
  logic [15:0] rd_data = 16'h0000;
  logic [31:0] wr_seen;
  int fails, samples_checked, n_ok, n_drop, n_rd;
  always #50 sys_clk = ~sys_clk;
  serial_slave_frame_check u_serial_slave_frame_check (
    .sys_clk_in(sys_clk), .sys_rst_in(sys_rst),
    .ascii_mode_in(ascii_mode), .station_addr_in(station),
    .char_cycles_in(16'h0014), .rx_byte_in(rx_byte),
    .rx_valid_in(rx_valid), .tx_byte_out(tx_byte),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .rd_req_out(rd_req), .wr_req_out(wr_req), .addr_out(addr),
    .wr_data_out(wr_data), .rd_data_in(rd_data),
    .frame_ok_out(frame_ok), .frame_drop_out(frame_drop));
  host_model u_host_model (
    .sys_clk_in(sys_clk), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .tx_byte_in(tx_byte), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .slow_in(slow));
  // word data is a scramble of its address so order slips show up
  always @(posedge sys_clk) begin
    n_ok += int'(frame_ok === 1'b1);
    n_drop += int'(frame_drop === 1'b1);
    n_rd += int'(rd_req === 1'b1);
    if (wr_req === 1'b1) wr_seen = {addr, wr_data};
    #1 rd_data = addr ^ 16'h5A00;
  end
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  function automatic bytes_t to_q(input logic [47:0] v);
    bytes_t q;
    for (int i = 5; i >= 0; i--) q.push_back(v[i*8 +: 8]);
    return q;
  endfunction : to_q
  task automatic run(input logic asc, input bytes_t frm, input bytes_t resp);
    @(posedge sys_clk);
    #1 ascii_mode = asc;
    n_ok = 0;
    n_drop = 0;
    n_rd = 0;
    u_host_model.got.delete();
    u_host_model.send(frm);
    for (int i = 0; i < 4000 && n_ok + n_drop == 0; i++) @(posedge sys_clk);
    for (int i = 0; i < 4000 && u_host_model.got.size() < resp.size(); i++)
      @(posedge sys_clk);
    repeat (30) @(posedge sys_clk);
    #1;
    check("ok", 16'(n_ok), 16'(resp.size() > 0));
    check("drop", 16'(n_drop), 16'(resp.size() == 0));
    check("len", 16'(u_host_model.got.size()), 16'(resp.size()));
    foreach (resp[i]) check("byte", u_host_model.got[i], resp[i]);
  endtask : run
  task automatic rtu_write();
    bytes_t req;
    req = to_q(48'h010600700001);
    slow = 1'b1;
    run(1'b0, u_host_model.enc(1'b0, req), u_host_model.enc(1'b0, req));
    slow = 1'b0;
    check("crc_lo", u_host_model.got[6], 8'h49);
    check("crc_hi", u_host_model.got[7], 8'hD1);
    check("wr_addr", wr_seen[31:16], 16'h0070);
    check("wr_data", wr_seen[15:0], 16'h0001);
  endtask : rtu_write
  task automatic ascii_write();
    bytes_t req;
    req = to_q(48'h010600700001);
    run(1'b1, u_host_model.enc(1'b1, req), u_host_model.enc(1'b1, req));
    check("lrc_hi", u_host_model.got[13], 8'h38);
    check("lrc_lo", u_host_model.got[14], 8'h38);
    check("end", {u_host_model.got[15], u_host_model.got[16]}, 16'h0D0A);
  endtask : ascii_write
  task automatic read_words(input logic asc, input logic [7:0] n);
    bytes_t resp;
    logic [15:0] w;
    resp = '{8'h01, 8'h03, {n[6:0], 1'b0}};
    for (int i = 0; i < int'(n); i++) begin
      w = (16'h0070 + 16'(i)) ^ 16'h5A00;
      resp = {resp, w[15:8], w[7:0]};
    end
    run(asc, u_host_model.enc(asc, to_q({40'h0103007000, n})),
        u_host_model.enc(asc, resp));
    check("reads", 16'(n_rd), {8'h00, n});
  endtask : read_words
  task automatic drops();
    logic [47:0] bad[5];
    bytes_t f, none;
    bad = '{48'h020600700001, 48'h000600700001, 48'h010400700001,
            48'h010300700000, 48'h01030070000D};
    for (int m = 0; m < 2; m++) begin
      foreach (bad[i]) run(m[0], u_host_model.enc(m[0], to_q(bad[i])), none);
      f = u_host_model.enc(m[0], to_q(48'h010600700001));
      f[f.size() - 3] = f[f.size() - 3] ^ 8'h01;
      run(m[0], f, none);
    end
  endtask : drops
  // edge stations: FE must answer, 00 and FF never may even when matched
  task automatic station_range();
    bytes_t q, none;
    station = 8'hFE;
    q = to_q(48'hFE0600700001);
    run(1'b0, u_host_model.enc(1'b0, q), u_host_model.enc(1'b0, q));
    check("wr_addr_fe", wr_seen[31:16], 16'h0070);
    station = 8'h00;
    q = to_q(48'h000600700001);
    run(1'b0, u_host_model.enc(1'b0, q), none);
    station = 8'hFF;
    q = to_q(48'hFF0600700001);
    run(1'b1, u_host_model.enc(1'b1, q), none);
    station = 8'h01;
  endtask : station_range
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    rtu_write();
    read_words(1'b0, 8'h01);
    read_words(1'b0, 8'h0C);
    ascii_write();
    read_words(1'b1, 8'h02);
    drops();
    station_range();
    stop_test();
  end
  initial begin
    #6000000;
    fails++;
    stop_test();
  end
endmodule : tb_top
